//--- hdl/btob_core.sv
// Execution logic for the bit-toggle and branch-on-overflow instructions.
// Assumes the fetch unit presents the instruction, incremented PC and the
// status overflow flag steady through Q1, and memory answers a read in Q2.
// Assumes bank select, extended-set enable and index base are steady in Q1.
// One instruction cycle is four CORE_CLK edges, Q1 to Q4.
// The status flags live elsewhere; nothing here can write them.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Toggle inverts only the chosen bit; other bits and status flags untouched.
// - Access bit 0 targets the access bank; 1 uses the bank select register.
// - Access 0, extended set on and address up to 5Fh uses indexed offset.
// - Overflow branch changes flow only when overflow flag is 1.
// - Taken target is incremented PC plus twice signed 8-bit offset.
// - Branch takes one cycle untaken, two taken; extra cycle is a discarded NOP.
module btob_core (
	input  wire logic                         CORE_CLK,
	input  wire logic                         RESET_N,
	input  wire logic [15:0]                  INSTR,
	input  wire logic [btob_pkg::PC_W-1:0]    PC_INCR,
	input  wire logic                         OV_FLAG,
	input  wire logic                         EXT_EN,
	input  wire logic [btob_pkg::BANK_W-1:0]  BANK_SEL,
	input  wire logic [btob_pkg::ADDR_W-1:0]  INDEX_BASE,
	input  wire logic [7:0]                   MEM_RDATA,
	output logic      [1:0]                   Q_PHASE,
	output logic      [btob_pkg::ADDR_W-1:0]  MEM_ADDR,
	output logic                              MEM_RD,
	output logic                              MEM_WR,
	output logic      [7:0]                   MEM_WDATA,
	output logic                              PC_WR,
	output logic      [btob_pkg::PC_W-1:0]    PC_NEXT,
	output logic                              FLUSH
);
	// ==========================================================
	// Reset release
	// Entry is immediate; release is lined up to the clock so the whole
	// state record leaves reset on one edge
	logic rst_meta_r;
	logic rst_sync_r;

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// ==========================================================
	// Decode
	logic                        is_tog;
	logic                        is_ovbr;
	logic                        tog_hit;
	logic                        br_hit;
	logic [2:0]                  bit_idx;
	logic [7:0]                  file_adr;
	logic                        acc_bit;
	logic                        low_half;
	logic [btob_pkg::ADDR_W-1:0] idx_addr;
	logic [btob_pkg::ADDR_W-1:0] banked_addr;
	logic [btob_pkg::ADDR_W-1:0] access_addr;
	logic [btob_pkg::ADDR_W-1:0] eff_addr;
	logic [btob_pkg::PC_W-1:0]   br_offset;
	logic [btob_pkg::PC_W-1:0]   br_target;

	assign is_tog   = INSTR[15:btob_pkg::TOG_OPC_LSB] == btob_pkg::OPC_TOGGLE_HI;
	assign is_ovbr  = INSTR[15:btob_pkg::BR_OPC_LSB] == btob_pkg::OPC_OVBR_HI;
	assign bit_idx  = INSTR[btob_pkg::TOG_BIT_LSB +: 3];
	assign file_adr = INSTR[7:0];
	assign acc_bit  = INSTR[btob_pkg::TOG_ACC_POS];
	assign low_half = file_adr <= btob_pkg::ACCESS_SPLIT;

	// ==========================================================
	// Address forming
	// Base pointer supplied by the indexing unit; the sum wraps inside the
	// data space, so the indexing unit keeps the base low when that matters
	assign idx_addr    = INDEX_BASE + {{btob_pkg::BANK_W{1'b0}}, file_adr};
	assign banked_addr = {BANK_SEL, file_adr};
	// Access bank: low half from bank 0, high half from the top bank
	assign access_addr = low_half ? {btob_pkg::ACC_LOW_BANK, file_adr}
		: {btob_pkg::ACC_HIGH_BANK, file_adr};

	always_comb begin
		if (acc_bit) begin
			eff_addr = banked_addr;
		end else if (EXT_EN && low_half) begin
			eff_addr = idx_addr;
		end else begin
			eff_addr = access_addr;
		end
	end

	// ==========================================================
	// Branch target
	// Offset is doubled because the counter addresses bytes of 16-bit words
	assign br_offset = {{(btob_pkg::PC_W-9){INSTR[7]}}, INSTR[7:0], 1'b0};
	assign br_target = PC_INCR + br_offset;

	// ==========================================================
	// State record
	// All state of the block except the two reset-sync flops lives in one packed record
	btob_pkg::btob_state_s st_r;
	btob_pkg::btob_state_s st_nxt;

	// A flushed cycle decodes nothing: the fetched word is dropped
	// Any other opcode leaves both hits low and the cycle passes as a no-op
	assign tog_hit = is_tog && !st_r.flush;
	assign br_hit  = is_ovbr && OV_FLAG && !st_r.flush;

	// ==========================================================
	// Toggle datapath
	// One lane per data bit; only the lane of the held index inverts, so the
	// other seven bits pass through untouched
	logic [7:0] lane_sel;
	logic [7:0] tog_data;

	generate
		for (genvar gi = 0; gi < 8; gi++) begin : g_lane
			assign lane_sel[gi] = st_r.bitsel == 3'(gi);
			assign tog_data[gi] = st_r.rdata[gi] ^ lane_sel[gi];
		end
	endgenerate

	// ==========================================================
	// Sequencer
	// Strobes default low so each one stands for exactly one phase
	always_comb begin
		st_nxt        = st_r;
		st_nxt.mem_rd = 1'b0;
		st_nxt.mem_wr = 1'b0;
		st_nxt.pc_wr  = 1'b0;
		case (st_r.phase)
			// Q1: decode; operands are captured only for a live cycle
			btob_pkg::Q1: begin
				st_nxt.phase  = btob_pkg::Q2;
				st_nxt.op_tog = tog_hit;
				st_nxt.taken  = br_hit;
				st_nxt.mem_rd = tog_hit;
				if (!st_r.flush) begin
					st_nxt.bitsel = bit_idx;
					st_nxt.addr   = eff_addr;
					st_nxt.pc_tgt = br_target;
				end
			end

			// Q2: the addressed register is read
			btob_pkg::Q2: begin
				st_nxt.phase = btob_pkg::Q3;
				// Read data is held only for a toggle; other opcodes leave it stale
				if (st_r.op_tog) begin
					st_nxt.rdata = MEM_RDATA;
				end
			end

			// Q3: process data
			btob_pkg::Q3: begin
				st_nxt.phase = btob_pkg::Q4;
				if (st_r.op_tog) begin
					st_nxt.wdata  = tog_data;
					st_nxt.mem_wr = 1'b1;
				end
				// Target lands on the counter in the final phase
				st_nxt.pc_wr = st_r.taken;
			end

			// Q4: write back; a taken branch turns the next cycle into a no-op
			btob_pkg::Q4: begin
				st_nxt.phase = btob_pkg::Q1;
				st_nxt.flush = st_r.taken;
			end

			// Unreachable with a two-bit phase; kept so a corrupt record heals
			default: begin
				st_nxt.phase = btob_pkg::Q1;
				st_nxt.flush = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// State register
	always_ff @(posedge CORE_CLK or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			st_r.phase  <= btob_pkg::Q1;
			st_r.flush  <= 1'b0;
			st_r.op_tog <= 1'b0;
			st_r.taken  <= 1'b0;
			st_r.bitsel <= 3'h0;
			st_r.addr   <= '0;
			st_r.rdata  <= 8'h00;
			st_r.wdata  <= 8'h00;
			st_r.pc_tgt <= btob_pkg::PC_RST;
			st_r.mem_rd <= 1'b0;
			st_r.mem_wr <= 1'b0;
			st_r.pc_wr  <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs
	// Every output is a flop of the state record, so memory and counter see no glitches
	assign Q_PHASE   = st_r.phase;
	assign MEM_ADDR  = st_r.addr;
	assign MEM_RD    = st_r.mem_rd;
	assign MEM_WR    = st_r.mem_wr;
	assign MEM_WDATA = st_r.wdata;
	assign PC_WR     = st_r.pc_wr;
	assign PC_NEXT   = st_r.pc_tgt;
	assign FLUSH     = st_r.flush;
endmodule // btob_core

`default_nettype wire

//--- hdl/btob_pkg.sv
// Package for the bit-toggle / overflow-branch execution block.
// Assumes a 16-bit instruction word and a four-phase instruction cycle.
package btob_pkg;
	// ==========================================================
	// Widths
	localparam int PC_W   = 21;
	localparam int BANK_W = 4;
	localparam int ADDR_W = BANK_W + 8;

	// ==========================================================
	// Opcode fields
	localparam logic [3:0] OPC_TOGGLE_HI = 4'h7;
	localparam logic [7:0] OPC_OVBR_HI   = 8'hE4;
	localparam int         TOG_OPC_LSB   = 12;
	localparam int         TOG_BIT_LSB   = 9;
	localparam int         TOG_ACC_POS   = 8;
	localparam int         BR_OPC_LSB    = 8;

	// ==========================================================
	// Addressing
	localparam logic [7:0]        ACCESS_SPLIT  = 8'h5F;
	localparam logic [BANK_W-1:0] ACC_LOW_BANK  = 4'h0;
	localparam logic [BANK_W-1:0] ACC_HIGH_BANK = 4'hF;

	// ==========================================================
	// Reset values
	localparam logic [15:0]     INSTR_RST = 16'h0000;
	localparam logic [PC_W-1:0] PC_RST    = 21'h000000;

	typedef enum logic [1:0] {
		Q1,
		Q2,
		Q3,
		Q4
	} btob_phase_e;

	typedef struct packed {
		btob_phase_e       phase;
		logic              flush;
		logic              op_tog;
		logic              taken;
		logic [2:0]        bitsel;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        rdata;
		logic [7:0]        wdata;
		logic [PC_W-1:0]   pc_tgt;
		logic              mem_rd;
		logic              mem_wr;
		logic              pc_wr;
	} btob_state_s;
endpackage : btob_pkg

//--- dv/btob_properties.sv
// Port checker for btob_core.
// Bound to every btob_core; assumes no instruction is presented during reset sync.
`timescale 1ns/10ps
`default_nettype none
module btob_properties (
	input wire logic        CORE_CLK,
	input wire logic        RESET_N,
	input wire logic        OV_FLAG,
	input wire logic        EXT_EN,
	input wire logic        MEM_RD,
	input wire logic        MEM_WR,
	input wire logic        PC_WR,
	input wire logic        FLUSH,
	input wire logic [15:0] INSTR,
	input wire logic [20:0] PC_INCR,
	input wire logic [20:0] PC_NEXT,
	input wire logic [3:0]  BANK_SEL,
	input wire logic [11:0] INDEX_BASE,
	input wire logic [11:0] MEM_ADDR,
	input wire logic [7:0]  MEM_RDATA,
	input wire logic [7:0]  MEM_WDATA,
	input wire logic [1:0]  Q_PHASE
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);
	wire tog = Q_PHASE == 2'h0 && !FLUSH && INSTR[15:12] == 4'h7;
	wire br  = Q_PHASE == 2'h0 && !FLUSH && INSTR[15:8] == 8'hE4;
	// ==========================================================
	// Properties
	AST_TOG_RD: assert property (tog |=> MEM_RD && !MEM_WR) else $error("no toggle read");
	AST_TOG_WR: assert property (MEM_RD |-> ##2 MEM_WR &&
		MEM_WDATA == ($past(MEM_RDATA, 2) ^ (8'h01 << $past(INSTR[11:9], 3))))
		else $error("toggle write wrong");
	AST_BANK: assert property (MEM_RD && $past(INSTR[8]) |->
		MEM_ADDR == {$past(BANK_SEL), $past(INSTR[7:0])}) else $error("banked address wrong");
	AST_INDEX: assert property (MEM_RD && !$past(INSTR[8]) && $past(EXT_EN) &&
		$past(INSTR[7:0]) <= 8'h5F |-> MEM_ADDR == $past(INDEX_BASE) + $past(INSTR[7:0]))
		else $error("indexed address wrong");
	AST_NO_JUMP: assert property (br && !OV_FLAG |-> ##3 !PC_WR ##1 !FLUSH) else $error("jumped");
	AST_TARGET: assert property (br && OV_FLAG |-> ##3 PC_WR && PC_NEXT == $past(PC_INCR, 3) +
		{{12{$past(INSTR[7], 3)}}, $past(INSTR[7:0], 3), 1'b0}) else $error("target wrong");
	AST_FLUSH: assert property (PC_WR |=> FLUSH [*4] ##1 !FLUSH) else $error("flush length");
	AST_QUIET: assert property (FLUSH |-> !MEM_RD && !MEM_WR && !PC_WR) else $error("busy in flush");
	cover property (tog);
	cover property (br && OV_FLAG);
	cover property (br && !OV_FLAG);
endmodule // btob_properties
bind btob_core btob_properties chk_u (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .OV_FLAG(OV_FLAG),
	.EXT_EN(EXT_EN), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .PC_WR(PC_WR), .FLUSH(FLUSH),
	.INSTR(INSTR), .PC_INCR(PC_INCR), .PC_NEXT(PC_NEXT), .BANK_SEL(BANK_SEL),
	.INDEX_BASE(INDEX_BASE), .MEM_ADDR(MEM_ADDR), .MEM_RDATA(MEM_RDATA),
	.MEM_WDATA(MEM_WDATA), .Q_PHASE(Q_PHASE));
`default_nettype wire

//--- dv/bit_toggle_and_overflow_branch_tb_top.sv
// Self-checking bench for btob_core: toggles, branches and other opcodes.
// Drives all inputs on the falling edge; no separate partner model.
`timescale 1ns/10ps
`default_nettype none
module bit_toggle_and_overflow_branch_tb_top;
	logic CORE_CLK = 0, RESET_N = 0, OV_FLAG = 0, EXT_EN = 0, MEM_RD, MEM_WR, PC_WR, FLUSH;
	logic [15:0] INSTR = 16'h0000;
	logic [20:0] PC_INCR = 21'h000000, PC_NEXT;
	logic [3:0]  BANK_SEL = 4'h0;
	logic [11:0] INDEX_BASE = 12'h000, MEM_ADDR;
	logic [7:0]  MEM_RDATA = 8'h00, MEM_WDATA, fld, r;
	logic [1:0]  Q_PHASE;
	logic [7:0]  edge_b [4] = '{8'h5F, 8'h60, 8'h7F, 8'h80};
	int bad_count = 0, checks = 0, seed = 88, i;
	btob_core dut_u (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .INSTR(INSTR), .PC_INCR(PC_INCR),
		.OV_FLAG(OV_FLAG), .EXT_EN(EXT_EN), .BANK_SEL(BANK_SEL), .INDEX_BASE(INDEX_BASE),
		.MEM_RDATA(MEM_RDATA), .Q_PHASE(Q_PHASE), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
		.MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA), .PC_WR(PC_WR), .PC_NEXT(PC_NEXT), .FLUSH(FLUSH));
	initial forever #2 CORE_CLK = ~CORE_CLK;
	task automatic chk(input string n, input logic [20:0] e, input logic [20:0] s);
		checks++;
		if (e !== s) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task conclude;
		if (bad_count == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ==========================================================
	// One instruction; model derives address, data and target
	task automatic run(input logic [15:0] ins, input logic ov);
		logic tg, jp;
		logic [11:0] ea;
		tg = ins[15:12] == 4'h7;
		jp = ins[15:8] == 8'hE4 && ov;
		do @(negedge CORE_CLK); while (Q_PHASE !== 2'h0 || FLUSH !== 1'b0);
		INSTR = ins;
		OV_FLAG = ov;
		EXT_EN = 1'($random(seed));
		BANK_SEL = 4'($random(seed));
		INDEX_BASE = 12'($random(seed));
		PC_INCR = 21'($random(seed));
		MEM_RDATA = 8'($random(seed));
		ea = ins[8] ? {BANK_SEL, ins[7:0]} : (ins[7:0] > 8'h5F) ? {4'hF, ins[7:0]} :
			EXT_EN ? INDEX_BASE + ins[7:0] : {4'h0, ins[7:0]};
		@(negedge CORE_CLK);
		chk("MEM_RD", tg, MEM_RD);
		if (tg) chk("MEM_ADDR", ea, MEM_ADDR);
		repeat (2) @(negedge CORE_CLK);
		chk("MEM_WR", tg, MEM_WR);
		if (tg) chk("MEM_WDATA", MEM_RDATA ^ (8'h01 << ins[11:9]), MEM_WDATA);
		chk("PC_WR", jp, PC_WR);
		if (jp) chk("PC_NEXT", PC_INCR + 21'(2 * $signed(ins[7:0])), PC_NEXT);
		chk("FLUSH", 1'b0, FLUSH);
		if (jp) begin
			@(negedge CORE_CLK);
			chk("FLUSH", 1'b1, FLUSH);
			// A toggle offered in the flushed cycle must be dropped
			INSTR = {4'h7, ins[11:0]};
			@(negedge CORE_CLK);
			chk("MEM_RD", 1'b0, MEM_RD);
		end
	endtask
	initial begin
		repeat (2) @(negedge CORE_CLK);
		RESET_N = 1;
		repeat (4) @(negedge CORE_CLK);
		// Back-to-back mix; first rounds hit the 5Fh split and offset extremes
		for (i = 0; i < 80; i++) begin
			r = 8'($random(seed));
			fld = (i < 16) ? edge_b[i / 4] : 8'($random(seed));
			case (i % 4)
				0: run({4'h7, r[2:0], r[3], fld}, 1'b0);
				1: run({8'hE4, fld}, 1'b1);
				2: run({8'hE4, fld}, 1'b0);
				default: run({4'h1, r[3:0], fld}, r[4]);
			endcase
		end
		conclude;
	end
	initial begin
		#20000;
		bad_count++;
		conclude;
	end
endmodule // bit_toggle_and_overflow_branch_tb_top
`default_nettype wire
